// ---- inc/olp_pkg.sv ----
// package of constants and types for the octet led pwm unit
package olp_pkg;
    // register indices; byte address is four times the index
    localparam logic [17:0] IDX_UNIT_CONFIG   = 18'h0a04c;
    localparam logic [17:0] IDX_CLOCK_PRESC   = 18'h0a04d;
    localparam logic [17:0] IDX_GROUP_FLAGS   = 18'h0a04e;
    localparam logic [17:0] IDX_TRIGGER_PTR   = 18'h0a04f;
    localparam logic [17:0] IDX_IRQ_STATUS    = 18'h0a050;
    localparam logic [17:0] IDX_IRQ_CLEAR     = 18'h0a051;
    localparam logic [17:0] IDX_CHANNEL0_DUTY = 18'h0a0a0;

    // field positions
    localparam int BIT_ZERO_FLAG = 0;
    localparam int BIT_TRG_FLAG  = 1;
    localparam int BIT_SYNC      = 7;

    // reset values, last count and full duty value
    localparam logic [7:0] RST_UNIT_CONFIG = 8'h00;
    localparam logic [7:0] RST_CLOCK_PRESC = 8'h00;
    localparam logic [7:0] RST_TRIGGER_PTR = 8'h00;
    localparam logic [7:0] RST_DUTY        = 8'h00;
    localparam logic [7:0] RST_COUNT       = 8'h00;
    localparam logic [7:0] CNT_LAST        = 8'hff;
    localparam logic [7:0] DUTY_FULL       = 8'hff;

    typedef struct packed {
        logic unit_run_enable;
        logic full_on_mode;
        logic rsvd5;
        logic group_update_enable;
        logic rsvd3;
        logic rsvd2;
        logic trigger_irq_enable;
        logic zero_irq_enable;
    } olp_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [19:0] paddr;
        logic [31:0] pwdata;
    } olp_apb_req_t;
endpackage

// ---- hw/olp_octet_pwm_unit.sv ----
// sixteen channel 8-bit led pwm unit with apb register access
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - sixteen pwm outputs, own 8-bit duty each
// - even channels left, odd channels right adjusted
// - duty shadowed, applied only at cycle start
// - disable finishes cycle, clears counter, outputs low
// - enable runs counter and waveforms normally
// - mode bit selects 255/256 or full on for duty ff
// - group update waits for trigger bit write
// - no group update: load every cycle start
// - trigger bit applies duties, then self clears
// - trigger flag set by hardware, software clears
// - zero flag set by hardware, software clears
// - trigger pointer compared left aligned always
// - duty registers 8-bit read write reset zero
module olp_octet_pwm_unit
    import olp_pkg::*;
#(
    parameter int NUM_CH = 16
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire olp_apb_req_t       apb_req,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic [NUM_CH-1:0]       led_pwm_out,
    output logic                    irq
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [17:0] idx;
    logic        setup_ph;
    logic        wr_acc;
    logic        is_duty;
    logic [3:0]  duty_sel;
    logic        mapped;

    assign idx      = apb_req.paddr[19:2];
    assign setup_ph = apb_req.psel && !apb_req.penable;
    assign wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign is_duty  = (idx[17:4] == IDX_CHANNEL0_DUTY[17:4]);
    assign duty_sel = idx[3:0];
    assign mapped   = is_duty || (idx == IDX_UNIT_CONFIG) || (idx == IDX_CLOCK_PRESC)
                      || (idx == IDX_GROUP_FLAGS) || (idx == IDX_TRIGGER_PTR)
                      || (idx == IDX_IRQ_STATUS) || (idx == IDX_IRQ_CLEAR);
    assign pready   = 1'b1;
    assign pslverr  = apb_req.psel && apb_req.penable && !mapped;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    olp_cfg_t   cfg_q;
    logic [7:0] cs_q;
    logic [7:0] trg_q;
    logic       sync_q;
    logic       zf_q;
    logic       tf_q;
    logic [7:0] shadow_q [NUM_CH];
    logic [7:0] act_q    [NUM_CH];
    logic [7:0] cnt_q;
    logic [7:0] presc_q;
    logic       run_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= olp_cfg_t'(RST_UNIT_CONFIG);
            cs_q  <= RST_CLOCK_PRESC;
            trg_q <= RST_TRIGGER_PTR;
        end else if (wr_acc) begin
            if (idx == IDX_UNIT_CONFIG) begin
                cfg_q <= olp_cfg_t'({apb_req.pwdata[7:6], 1'b0, apb_req.pwdata[4],
                                     2'b00, apb_req.pwdata[1:0]});
            end
            if (idx == IDX_CLOCK_PRESC) begin
                cs_q <= apb_req.pwdata[7:0];
            end
            if (idx == IDX_TRIGGER_PTR) begin
                trg_q <= apb_req.pwdata[7:0];
            end
        end
    end

    // shadow duty registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                shadow_q[i] <= RST_DUTY;
            end
        end else if (wr_acc && is_duty) begin
            shadow_q[duty_sel] <= apb_req.pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter, prescaler and run control

    logic       step;
    logic       wrap;
    logic       start;
    logic       stop;
    logic       cyc_start;
    logic       load;
    logic [7:0] cnt_nx;
    logic       zero_ev;
    logic       trg_ev;

    assign step      = run_q && (presc_q >= cs_q);
    assign wrap      = step && (cnt_q == CNT_LAST);
    assign start     = !run_q && cfg_q.unit_run_enable;
    assign stop      = wrap && !cfg_q.unit_run_enable;
    assign cyc_start = start || (wrap && cfg_q.unit_run_enable);
    assign load      = cyc_start && (!cfg_q.group_update_enable || sync_q);
    assign cnt_nx    = cnt_q + 8'h01;
    assign zero_ev   = wrap && !stop;
    assign trg_ev    = step && !stop && (cnt_nx == trg_q);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= RST_COUNT;
        end else if (!run_q || step) begin
            presc_q <= RST_COUNT;
        end else begin
            presc_q <= presc_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= RST_COUNT;
        end else if (stop) begin
            cnt_q <= RST_COUNT;
        end else if (step) begin
            cnt_q <= cnt_nx;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (start) begin
            run_q <= 1'b1;
        end else if (stop) begin
            run_q <= 1'b0;
        end
    end

    // active duties change only at a cycle start
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                act_q[i] <= RST_DUTY;
            end
        end else if (load) begin
            for (int i = 0; i < NUM_CH; i++) begin
                act_q[i] <= shadow_q[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // group update bit and event flags

    logic wr_grp;
    logic clr_zf;
    logic clr_tf;

    assign wr_grp = wr_acc && (idx == IDX_GROUP_FLAGS);
    assign clr_zf = wr_acc && apb_req.pwdata[BIT_ZERO_FLAG]
                    && ((idx == IDX_GROUP_FLAGS) || (idx == IDX_IRQ_CLEAR));
    assign clr_tf = wr_acc && apb_req.pwdata[BIT_TRG_FLAG]
                    && ((idx == IDX_GROUP_FLAGS) || (idx == IDX_IRQ_CLEAR));

    // a new trigger write wins over the self clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 1'b0;
        end else if (wr_grp && apb_req.pwdata[BIT_SYNC]) begin
            sync_q <= 1'b1;
        end else if (load) begin
            sync_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            zf_q <= 1'b0;
        end else if (zero_ev) begin
            zf_q <= 1'b1;
        end else if (clr_zf) begin
            zf_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tf_q <= 1'b0;
        end else if (trg_ev) begin
            tf_q <= 1'b1;
        end else if (clr_tf) begin
            tf_q <= 1'b0;
        end
    end

    assign irq = (zf_q && cfg_q.zero_irq_enable) || (tf_q && cfg_q.trigger_irq_enable);

    ////////////////////////////////////////////////////////////////////////////
    // channel waveforms

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        logic hi;
        logic full;
        logic lit_q;
        // odd channels mirror the count so the pulse ends with the period
        if (ch % 2 == 0) begin : g_left
            assign hi = (cnt_q < act_q[ch]);
        end else begin : g_right
            assign hi = ((CNT_LAST - cnt_q) < act_q[ch]);
        end
        assign full = cfg_q.full_on_mode && (act_q[ch] == DUTY_FULL);
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                lit_q <= 1'b0;
            end else begin
                lit_q <= run_q && (hi || full);
            end
        end
        assign led_pwm_out[ch] = lit_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, latched in the setup phase

    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (is_duty) begin
            rd_byte = shadow_q[duty_sel];
        end else if (idx == IDX_UNIT_CONFIG) begin
            rd_byte = cfg_q;
        end else if (idx == IDX_CLOCK_PRESC) begin
            rd_byte = cs_q;
        end else if (idx == IDX_GROUP_FLAGS) begin
            rd_byte = {sync_q, 5'b00000, tf_q, zf_q};
        end else if (idx == IDX_TRIGGER_PTR) begin
            rd_byte = trg_q;
        end else if (idx == IDX_IRQ_STATUS) begin
            rd_byte = {6'b000000, tf_q, zf_q};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= {24'h000000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic cs_wr;

    // a prescale write changes the step spacing, so the spacing checks skip it
    assign cs_wr = wr_acc && (idx == IDX_CLOCK_PRESC);

    a_idle_outputs_low: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !run_q |=> (led_pwm_out == '0))
        else $error("outputs not low while stopped");

    a_stop_at_end: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $fell(run_q) |-> ($past(cnt_q) == 8'hff) && (cnt_q == 8'h00))
        else $error("unit stopped before the cycle ended");

    a_zero_flag_set: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (run_q && step && cnt_q == 8'hff && cfg_q.unit_run_enable) |=> zf_q)
        else $error("zero flag not set on wrap");

    a_trg_flag_set: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (step && !stop && cnt_nx == trg_q) |=> tf_q && (cnt_q == $past(trg_q)))
        else $error("trigger flag not set on match");

    a_irq_gate: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        irq == ((zf_q && cfg_q.zero_irq_enable) || (tf_q && cfg_q.trigger_irq_enable)))
        else $error("interrupt not gated by enables");

    a_duty_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (act_q[0] != $past(act_q[0])) |-> $past(cyc_start) && (cnt_q == 8'h00))
        else $error("active duty changed mid period");

    a_group_wait: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (cfg_q.group_update_enable && !sync_q) |-> !load)
        else $error("group update applied without trigger");

    a_sync_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (load && !(wr_grp && apb_req.pwdata[BIT_SYNC])) |=> !sync_q)
        else $error("trigger bit did not self clear");

    a_left_adjust: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (run_q && !cfg_q.full_on_mode) |=> (led_pwm_out[0] == ($past(cnt_q) < $past(act_q[0]))))
        else $error("even channel not left adjusted");

    a_prescale_gap: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (step && !stop && cs_q == 8'h01 && !cs_wr) |=> !step)
        else $error("counter stepped on two clocks in a row");

    a_prescale_step: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (step && !stop && cs_q == 8'h01 && !cs_wr) ##1 !cs_wr |=> step)
        else $error("counter missed its scaled step");

    a_right_adjust: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (run_q && !cfg_q.full_on_mode) |=> (led_pwm_out[1] ==
            (({1'b0, $past(cnt_q)} + {1'b0, $past(act_q[1])}) > {1'b0, CNT_LAST})))
        else $error("odd channel not right adjusted");

    a_full_on_mode: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (run_q && cfg_q.full_on_mode && act_q[2] == DUTY_FULL) |=> led_pwm_out[2])
        else $error("full duty not held on in full on mode");

    a_run_start: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        start |=> run_q && (cnt_q == RST_COUNT))
        else $error("unit did not start from count zero");

    a_count_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!step && !stop) |=> (cnt_q == $past(cnt_q)))
        else $error("counter moved without a step");

    a_zero_wrap: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        zero_ev |=> (cnt_q == RST_COUNT))
        else $error("zero event without wrap to zero");

    a_trg_sticky: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (tf_q && !clr_tf) |=> tf_q)
        else $error("trigger flag cleared without software");

    a_trg_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (clr_tf && !trg_ev) |=> !tf_q)
        else $error("trigger flag not cleared by software");

    a_zero_sticky: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (zf_q && !clr_zf) |=> zf_q)
        else $error("zero flag cleared without software");

    a_zero_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (clr_zf && !zero_ev) |=> !zf_q)
        else $error("zero flag not cleared by software");

endmodule

`default_nettype wire

// ---- test/olp_led_sink_model.sv ----
// led current sink model: counts lit samples per channel
`timescale 1ns/10ps
`default_nettype none
module olp_led_sink_model (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [15:0]       led_pwm_out,
    input  wire logic              clear_count,
    output logic [15:0][9:0]       on_cnt,
    output logic [9:0]             overlap
);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            on_cnt  <= '0;
            overlap <= '0;
        end else if (clear_count) begin
            on_cnt  <= '0;
            overlap <= '0;
        end else begin
            for (int i = 0; i < 16; i++) begin
                on_cnt[i] <= on_cnt[i] + 10'(led_pwm_out[i]);
            end
            // sinks of channel 0 and channel 1 lit together
            overlap <= overlap + 10'(led_pwm_out[0] & led_pwm_out[1]);
        end
    end
endmodule
`default_nettype wire

// ---- test/octet_led_pwm_controller_bench.sv ----
// testbench for the octet led pwm unit
`timescale 1ns/10ps
`default_nettype none
module octet_led_pwm_controller_bench
    import olp_pkg::*;
;
    logic core_clk, rst_n, pready, pslverr, irq, clr;
    olp_apb_req_t req;
    logic [31:0] prdata;
    logic [15:0] led;
    logic [15:0][9:0] on_cnt;
    logic [9:0] overlap;
    logic [7:0] rd;
    logic err;
    int mismatches, check_count, n;
    olp_octet_pwm_unit #(.NUM_CH(16)) olp_octet_pwm_unit_i (
        .core_clk(core_clk), .rst_n(rst_n), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .led_pwm_out(led), .irq(irq));
    olp_led_sink_model olp_led_sink_model_i (
        .core_clk(core_clk), .rst_n(rst_n), .led_pwm_out(led),
        .clear_count(clr), .on_cnt(on_cnt), .overlap(overlap));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task test_done();
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask
    task apb(input logic w, input logic [17:0] idx, input logic [7:0] wd);
        int k;
        @(posedge core_clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            test_done();
        end
        rd = prdata[7:0];
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task rchk(input logic [17:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk("register", {8'h00, exp}, {8'h00, rd});
    endtask
    // settle a period or two, then count cyc samples in the sink model
    task measure(input int cyc);
        repeat (520) @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        repeat (cyc) @(posedge core_clk);
        #1;
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        mismatches++;
        test_done();
    end
    initial begin
        rst_n = 1'b0;
        clr = 1'b0;
        req = '0;
        mismatches = 0;
        check_count = 0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(IDX_UNIT_CONFIG, RST_UNIT_CONFIG);
        rchk(IDX_CLOCK_PRESC, RST_CLOCK_PRESC);
        rchk(IDX_GROUP_FLAGS, 8'h00);
        rchk(IDX_TRIGGER_PTR, RST_TRIGGER_PTR);
        rchk(IDX_CHANNEL0_DUTY, RST_DUTY);
        apb(1'b0, 18'h0a060, 8'h00);
        chk("unmapped error", 16'h0001, {15'h0, err});
        chk("unmapped read", 16'h0000, {8'h00, rd});
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, IDX_CHANNEL0_DUTY + 18'(c), 8'(c * 17 + 5));
            rchk(IDX_CHANNEL0_DUTY + 18'(c), 8'(c * 17 + 5));
        end
        apb(1'b1, IDX_CHANNEL0_DUTY, 8'h02);
        apb(1'b1, IDX_CHANNEL0_DUTY + 18'h1, 8'h03);
        apb(1'b1, IDX_CHANNEL0_DUTY + 18'h2, DUTY_FULL);
        apb(1'b1, IDX_TRIGGER_PTR, 8'h10);
        apb(1'b1, IDX_UNIT_CONFIG, 8'h80);
        measure(256);
        chk("even width", 16'd2, 16'(on_cnt[0]));
        chk("odd width", 16'd3, 16'(on_cnt[1]));
        chk("even odd overlap", 16'd0, 16'(overlap));
        chk("full duty off mode", 16'd255, 16'(on_cnt[2]));
        apb(1'b1, IDX_UNIT_CONFIG, 8'hc0);
        measure(256);
        chk("full duty on mode", 16'd256, 16'(on_cnt[2]));
        apb(1'b1, IDX_CLOCK_PRESC, 8'h01);
        apb(1'b1, IDX_UNIT_CONFIG, 8'h80);
        apb(1'b1, IDX_CHANNEL0_DUTY, 8'd100);
        measure(512);
        chk("scaled width", 16'd200, 16'(on_cnt[0]));
        apb(1'b1, IDX_CLOCK_PRESC, 8'h00);
        apb(1'b1, IDX_UNIT_CONFIG, 8'h90);
        apb(1'b1, IDX_CHANNEL0_DUTY, 8'd50);
        measure(256);
        chk("held duty", 16'd100, 16'(on_cnt[0]));
        apb(1'b1, IDX_GROUP_FLAGS, 8'h80);
        measure(256);
        chk("group loaded duty", 16'd50, 16'(on_cnt[0]));
        apb(1'b0, IDX_GROUP_FLAGS, 8'h00);
        chk("sync self clear", 16'h0000, {15'h0, rd[BIT_SYNC]});
        apb(1'b1, IDX_UNIT_CONFIG, 8'h00);
        #1;
        n = 0;
        repeat (8) begin
            @(posedge core_clk);
            #1;
            n += int'(led[2]);
        end
        chk("cycle finishes", 16'h0001, {15'h0, n != 0});
        repeat (300) @(posedge core_clk);
        #1;
        chk("stopped outputs", 16'h0000, led);
        apb(1'b1, IDX_IRQ_CLEAR, 8'h03);
        rchk(IDX_IRQ_STATUS, 8'h00);
        repeat (300) @(posedge core_clk);
        rchk(IDX_IRQ_STATUS, 8'h00);
        #1;
        chk("irq idle", 16'h0000, {15'h0, irq});
        apb(1'b1, IDX_UNIT_CONFIG, 8'h80);
        repeat (300) @(posedge core_clk);
        rchk(IDX_IRQ_STATUS, 8'h03);
        #1;
        chk("irq masked", 16'h0000, {15'h0, irq});
        apb(1'b1, IDX_UNIT_CONFIG, 8'h82);
        #1;
        chk("irq enabled", 16'h0001, {15'h0, irq});
        apb(1'b1, IDX_UNIT_CONFIG, 8'h01);
        repeat (300) @(posedge core_clk);
        apb(1'b1, IDX_GROUP_FLAGS, 8'h02);
        rchk(IDX_IRQ_STATUS, 8'h01);
        #1;
        chk("irq zero path", 16'h0001, {15'h0, irq});
        apb(1'b1, IDX_GROUP_FLAGS, 8'h01);
        #1;
        chk("irq cleared", 16'h0000, {15'h0, irq});
        test_done();
    end
endmodule
`default_nettype wire
